// *** src/rxseq_pkg.sv ***
// Purpose: shared constants and carrier types of the receiver operation sequencer
// Assumes: 25 MHz core clock, AHB-Lite register port with 32-bit data
// Notes:   the timing durations are given in their own unit and turned into cycle counts here
package rxseq_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PWRUP_ALWAYS_NS = 4_000_000;
    localparam int unsigned PWRUP_DUTY_NS = 9_500_000;
    localparam int unsigned SLEEP_FIXED_NS = 3_000_000;
    localparam int unsigned TUNE_NS = 300_000;
    localparam int unsigned LPO_PERIOD_NS = 1_000_000;
    localparam int unsigned RX_UNIT_NS = 40_000;
    localparam int unsigned PWRUP_ALWAYS_CYC = PWRUP_ALWAYS_NS / CLK_PERIOD_NS;
    localparam int unsigned PWRUP_DUTY_CYC = PWRUP_DUTY_NS / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_FIXED_CYC = SLEEP_FIXED_NS / CLK_PERIOD_NS;
    localparam int unsigned TUNE_CYC = TUNE_NS / CLK_PERIOD_NS;
    localparam int unsigned LPO_CYC = LPO_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned RX_UNIT_CYC = (RX_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************
    // Duration limits
    // ********************************
    localparam logic [26:0] SLEEP_MIN_MS = 27'h0000003;
    localparam logic [26:0] SLEEP_MAX_MS = 27'h7ff0000;
    localparam logic [26:0] RX_MIN_UNITS = 27'h0000001;
    localparam logic [26:0] RX_MAX_UNITS = 27'h3ff7feb;
    localparam logic [26:0] XTAL_MIN_UNITS = 27'h0000001;
    localparam logic [26:0] XTAL_MAX_UNITS = 27'h000ffff;

    // ********************************
    // Register map
    // ********************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SLEEP = 12'h004;
    localparam logic [11:0] ADDR_RXTIME = 12'h008;
    localparam logic [11:0] ADDR_XTAL = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam int CTRL_DUTY_BIT = 0;
    localparam int CTRL_SYSCLK_BIT = 1;
    localparam int CTRL_DIV_LSB = 8;
    localparam int CTRL_DIV_W = 5;
    localparam int CTRL_START_BIT = 31;
    localparam int STAT_LOCK_BIT = 8;
    localparam int STAT_DUTY_BIT = 9;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [26:0] SLEEP_RST = 27'h0000003;
    localparam logic [26:0] RXTIME_RST = 27'h000c350;
    localparam logic [15:0] XTAL_RST = 16'h0008;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [2:0] {ST_OFF, ST_PWRUP, ST_SLEEP, ST_XTAL, ST_TUNE, ST_RX} rxseq_state_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } rxseq_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } rxseq_ahb_rsp_t;

    typedef struct packed {
        logic dout;
        logic sys_clock_out;
    } rxseq_pins_t;

    typedef struct packed {
        logic xtal_on;
        logic lpo_on;
        logic lpo_cal;
        logic rf_on;
    } rxseq_pwr_t;

endpackage

// *** src/rxseq_top.sv ***
// Purpose: operating-state sequencer of a stand-alone receiver, with AHB-Lite settings
// Assumes: one 25 MHz clock, synchronous active-high reset, demodulator data arrives async
// Notes:   settings are loaded by software, then frozen by the start bit until reset
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module rxseq_top #(
    parameter int unsigned P_PWRUP_ALWAYS_CYC = rxseq_pkg::PWRUP_ALWAYS_CYC,
    parameter int unsigned P_PWRUP_DUTY_CYC = rxseq_pkg::PWRUP_DUTY_CYC,
    parameter int unsigned P_SLEEP_FIXED_CYC = rxseq_pkg::SLEEP_FIXED_CYC,
    parameter int unsigned P_TUNE_CYC = rxseq_pkg::TUNE_CYC,
    parameter int unsigned P_LPO_CYC = rxseq_pkg::LPO_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Register bus
    input wire rxseq_pkg::rxseq_ahb_req_t i_ahb,
    output rxseq_pkg::rxseq_ahb_rsp_t o_ahb,
    // Demodulator data, asynchronous
    input wire logic i_demod_data,
    // Pins toward the microcontroller
    output rxseq_pkg::rxseq_pins_t o_pins,
    // Power and calibration controls
    output rxseq_pkg::rxseq_pwr_t o_pwr
);
    import rxseq_pkg::*;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        rxseq_state_t state;
        logic [31:0] ctrl;
        logic [26:0] sleep_ms;
        logic [26:0] rx_units;
        logic [15:0] xtal_units;
        logic cfg_duty;
        logic cfg_sysclk;
        logic [CTRL_DIV_W-1:0] cfg_div;
        logic [26:0] cfg_sleep;
        logic [26:0] cfg_rx;
        logic [26:0] cfg_xtal;
        logic [31:0] cyc_cnt;
        logic [31:0] lpo_div;
        logic [15:0] unit_div;
        logic [26:0] dur_cnt;
        logic [CTRL_DIV_W-1:0] clk_cnt;
        logic din_s1;
        logic din_s2;
        logic wr_pend;
        logic [11:0] wr_addr;
        rxseq_ahb_rsp_t rsp;
        rxseq_pins_t pins;
        rxseq_pwr_t pwr;
    } rxseq_st_t;

    rxseq_st_t r_ff;
    rxseq_st_t nxt_r;

    // ********************************
    // Helpers
    // ********************************
    // True on the event that completes a span of lim events.
    // Counters start at zero on state entry, so lim events take exactly lim steps;
    // the extra top bit keeps a full-scale count from wrapping to zero and missing the end.
    function automatic logic f_last(input logic [31:0] cnt, input logic [31:0] lim);
        return ({1'b0, cnt} + 33'h000000001) >= {1'b0, lim};
    endfunction

    // Out-of-range settings are pulled to the nearest legal duration rather than
    // refused, so a careless write can never stall the sequencer in one state.
    function automatic logic [26:0] f_clamp(input logic [26:0] v, input logic [26:0] lo,
                                            input logic [26:0] hi);
        logic [26:0] res;
        res = v;
        if (v < lo) begin
            res = lo;
        end else if (v > hi) begin
            res = hi;
        end
        return res;
    endfunction

    // ********************************
    // Next state
    // ********************************
    logic acc;
    logic go;
    logic lpo_tick;
    logic unit_tick;
    logic clk_gate;

    always_comb begin
        nxt_r = r_ff;
        acc = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
        go = 1'b0;

        // Demod data comes from the analog domain
        nxt_r.din_s1 = i_demod_data;
        nxt_r.din_s2 = r_ff.din_s1;

        // Register writes in the data phase
        nxt_r.wr_pend = acc & i_ahb.hwrite;
        nxt_r.wr_addr = i_ahb.haddr[11:0];
        if (r_ff.wr_pend) begin
            unique case (r_ff.wr_addr)
                ADDR_CTRL: begin
                    nxt_r.ctrl = i_ahb.hwdata & ~(32'h1 << CTRL_START_BIT);
                    go = i_ahb.hwdata[CTRL_START_BIT];
                end
                ADDR_SLEEP: nxt_r.sleep_ms = i_ahb.hwdata[26:0];
                ADDR_RXTIME: nxt_r.rx_units = i_ahb.hwdata[26:0];
                ADDR_XTAL: nxt_r.xtal_units = i_ahb.hwdata[15:0];
                default: ;
            endcase
        end

        // Read data is prepared in the address phase; bypass makes write-then-read coherent
        nxt_r.rsp.hreadyout = 1'b1;
        nxt_r.rsp.hresp = 1'b0;
        nxt_r.rsp.hrdata = 32'h0;
        if (acc && !i_ahb.hwrite) begin
            unique case (i_ahb.haddr[11:0])
                ADDR_CTRL: nxt_r.rsp.hrdata = nxt_r.ctrl;
                ADDR_SLEEP: nxt_r.rsp.hrdata = {5'h00, nxt_r.sleep_ms};
                ADDR_RXTIME: nxt_r.rsp.hrdata = {5'h00, nxt_r.rx_units};
                ADDR_XTAL: nxt_r.rsp.hrdata = {16'h0000, nxt_r.xtal_units};
                ADDR_STATUS: begin
                    nxt_r.rsp.hrdata[2:0] = r_ff.state;
                    nxt_r.rsp.hrdata[STAT_LOCK_BIT] = (r_ff.state != ST_OFF);
                    nxt_r.rsp.hrdata[STAT_DUTY_BIT] = r_ff.cfg_duty;
                end
                default: nxt_r.rsp.hrdata = 32'h0;
            endcase
        end

        // Sleep timer tick from the low-power oscillator, 1 ms nominal
        lpo_tick = 1'b0;
        if (r_ff.pwr.lpo_on) begin
            if (r_ff.lpo_div == 32'(P_LPO_CYC - 1)) begin
                nxt_r.lpo_div = 32'h0;
                lpo_tick = 1'b1;
            end else begin
                nxt_r.lpo_div = r_ff.lpo_div + 32'h1;
            end
        end else begin
            nxt_r.lpo_div = 32'h0;
        end

        // 40 us time base for crystal settling and receive time.
        // It is not shortened with the other counts, so one unit is always 40 us;
        // the divider restarts on every state change so the first unit is whole.
        unit_tick = 1'b0;
        if (r_ff.unit_div == 16'(RX_UNIT_CYC - 1)) begin
            nxt_r.unit_div = 16'h0;
            unit_tick = 1'b1;
        end else begin
            nxt_r.unit_div = r_ff.unit_div + 16'h1;
        end

        nxt_r.cyc_cnt = r_ff.cyc_cnt + 32'h1;

        unique case (r_ff.state)
            ST_OFF: begin
                if (go) begin
                    // Settings freeze here; later writes only change the shadow copy
                    nxt_r.cfg_duty = nxt_r.ctrl[CTRL_DUTY_BIT];
                    nxt_r.cfg_sysclk = nxt_r.ctrl[CTRL_SYSCLK_BIT];
                    nxt_r.cfg_div = nxt_r.ctrl[CTRL_DIV_LSB +: CTRL_DIV_W];
                    nxt_r.cfg_sleep = f_clamp(nxt_r.sleep_ms, SLEEP_MIN_MS, SLEEP_MAX_MS);
                    nxt_r.cfg_rx = f_clamp(nxt_r.rx_units, RX_MIN_UNITS, RX_MAX_UNITS);
                    nxt_r.cfg_xtal = f_clamp({11'h000, nxt_r.xtal_units}, XTAL_MIN_UNITS,
                                             XTAL_MAX_UNITS);
                    nxt_r.state = ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                // Duty mode needs the longer phase to calibrate the sleep timer
                if (f_last(r_ff.cyc_cnt, r_ff.cfg_duty ? 32'(P_PWRUP_DUTY_CYC)
                                                       : 32'(P_PWRUP_ALWAYS_CYC))) begin
                    nxt_r.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (r_ff.cfg_duty) begin
                    if (lpo_tick) begin
                        nxt_r.dur_cnt = r_ff.dur_cnt + 27'h1;
                        if (f_last({5'h00, r_ff.dur_cnt}, {5'h00, r_ff.cfg_sleep})) begin
                            nxt_r.state = ST_XTAL;
                        end
                    end
                end else if (f_last(r_ff.cyc_cnt, 32'(P_SLEEP_FIXED_CYC))) begin
                    nxt_r.state = ST_TUNE;
                end
            end
            ST_XTAL: begin
                // Only reachable in duty mode; always-receive goes from sleep to tuning
                if (unit_tick) begin
                    nxt_r.dur_cnt = r_ff.dur_cnt + 27'h1;
                    if (f_last({5'h00, r_ff.dur_cnt}, {5'h00, r_ff.cfg_xtal})) begin
                        nxt_r.state = ST_TUNE;
                    end
                end
            end
            ST_TUNE: begin
                if (f_last(r_ff.cyc_cnt, 32'(P_TUNE_CYC))) begin
                    nxt_r.state = ST_RX;
                end
            end
            ST_RX: begin
                // Always-receive never leaves this state until reset
                if (r_ff.cfg_duty && unit_tick) begin
                    nxt_r.dur_cnt = r_ff.dur_cnt + 27'h1;
                    if (f_last({5'h00, r_ff.dur_cnt}, {5'h00, r_ff.cfg_rx})) begin
                        nxt_r.state = ST_SLEEP;
                    end
                end
            end
        endcase

        // Every state starts its timers from zero
        if (nxt_r.state != r_ff.state) begin
            nxt_r.cyc_cnt = 32'h0;
            nxt_r.dur_cnt = 27'h0;
            nxt_r.unit_div = 16'h0;
            nxt_r.lpo_div = 32'h0;
        end

        // Power controls follow the next state so they switch with it
        // Limitation: these are enables only; the analog blocks own their settling
        nxt_r.pwr.xtal_on = (nxt_r.state == ST_PWRUP) || (nxt_r.state == ST_XTAL)
                            || (nxt_r.state == ST_TUNE) || (nxt_r.state == ST_RX);
        nxt_r.pwr.rf_on = (nxt_r.state == ST_TUNE) || (nxt_r.state == ST_RX);
        nxt_r.pwr.lpo_on = (nxt_r.state != ST_OFF) && nxt_r.cfg_duty;
        nxt_r.pwr.lpo_cal = (nxt_r.state == ST_PWRUP) && nxt_r.cfg_duty;

        // Data pin only carries demodulated data while receiving
        nxt_r.pins.dout = (nxt_r.state == ST_RX) ? r_ff.din_s2 : 1'b0;

        // Divided system clock, gated off outside tuning and reception (rf_on low), so it also runs while tuning
        // The gate follows the next state so the clock stops in the same cycle as the
        // receive chain and never leaves a short high pulse behind on the pin.
        clk_gate = r_ff.cfg_sysclk && nxt_r.pwr.rf_on;
        if (!clk_gate) begin
            nxt_r.clk_cnt = '0;
            nxt_r.pins.sys_clock_out = 1'b0;
        end else if (r_ff.clk_cnt == r_ff.cfg_div) begin
            nxt_r.clk_cnt = '0;
            nxt_r.pins.sys_clock_out = ~r_ff.pins.sys_clock_out;
        end else begin
            nxt_r.clk_cnt = r_ff.clk_cnt + 1'b1;
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_ff <= '0;
            r_ff.state <= ST_OFF;
            r_ff.ctrl <= CTRL_RST;
            r_ff.sleep_ms <= SLEEP_RST;
            r_ff.rx_units <= RXTIME_RST;
            r_ff.xtal_units <= XTAL_RST;
            r_ff.rsp.hreadyout <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // All outputs are plain register bits, so no decode glitch reaches a pin
    assign o_ahb = r_ff.rsp;
    assign o_pins = r_ff.pins;
    assign o_pwr = r_ff.pwr;

endmodule

// *** dv/rxseq_chk.sv ***
// Purpose: port assertions of the receiver sequencer
// Assumes: shortened counts handed on by the bind
// Notes:   sees power and pin outputs only, so tuning and receive share one pattern
`timescale 1ns/100ps
module rxseq_chk #(
    parameter int unsigned P_PWRUP_ALWAYS_CYC = 40,
    parameter int unsigned P_PWRUP_DUTY_CYC = 95,
    parameter int unsigned P_SLEEP_FIXED_CYC = 30
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Watched outputs
    input rxseq_pkg::rxseq_pins_t o_pins,
    input rxseq_pkg::rxseq_pwr_t o_pwr
);
    import rxseq_pkg::*;
    localparam int D_PA = P_PWRUP_ALWAYS_CYC - 1;
    localparam int D_PD = P_PWRUP_DUTY_CYC - 1;
    localparam int D_SL = P_SLEEP_FIXED_CYC - 1;
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    AST_DOUT_IDLE: assert property (!o_pwr.rf_on |-> !o_pins.dout)
        else $error("data pin high outside reception");
    AST_SYSCLK_GATED: assert property (!o_pwr.rf_on |-> !o_pins.sys_clock_out)
        else $error("clock output outside tune and receive");
    AST_SLEEP_DARK: assert property (!o_pwr.xtal_on |-> !o_pwr.rf_on && !o_pwr.lpo_cal)
        else $error("block powered while crystal off");
    AST_CAL_IN_PWRUP: assert property (o_pwr.lpo_cal |-> o_pwr.lpo_on && o_pwr.xtal_on)
        else $error("calibration outside power-up");
    AST_ALWAYS_SEQ: assert property ($rose(o_pwr.xtal_on) && !o_pwr.lpo_on && !o_pwr.rf_on
        |-> ##D_PA o_pwr.xtal_on ##1 !o_pwr.xtal_on ##D_SL !o_pwr.xtal_on ##1 o_pwr.rf_on)
        else $error("always-receive power-up or sleep length wrong");
    AST_DUTY_PWRUP: assert property ($rose(o_pwr.lpo_cal)
        |-> ##D_PD o_pwr.lpo_cal ##1 (!o_pwr.lpo_cal && !o_pwr.xtal_on))
        else $error("duty power-up length wrong");
    AST_TUNE_NO_XTAL: assert property ($rose(o_pwr.rf_on) && !o_pwr.lpo_on
        |-> $rose(o_pwr.xtal_on)) else $error("settling state in always mode");
    AST_TUNE_AFTER_XTAL: assert property ($rose(o_pwr.rf_on) && o_pwr.lpo_on
        |-> $past(o_pwr.xtal_on) && !$past(o_pwr.lpo_cal)) else $error("tune without settling");
    AST_RX_EXIT: assert property ($fell(o_pwr.rf_on) |-> o_pwr.lpo_on && !o_pwr.xtal_on)
        else $error("receive left wrongly");
endmodule
bind rxseq_top rxseq_chk #(.P_PWRUP_ALWAYS_CYC(P_PWRUP_ALWAYS_CYC),
    .P_PWRUP_DUTY_CYC(P_PWRUP_DUTY_CYC),
    .P_SLEEP_FIXED_CYC(P_SLEEP_FIXED_CYC)) u_rxseq_chk (.i_clock(i_clock), .i_reset(i_reset),
    .o_pins(o_pins), .o_pwr(o_pwr));

// *** dv/rxseq_mcu.sv ***
// Purpose: microcontroller that polls the data pin
// Assumes: samples once per core clock
// Notes:   adds one cycle of latency to what the bench sees
`timescale 1ns/100ps
module rxseq_mcu (
    // Clock
    input wire logic i_clock,
    // Data pin
    input wire logic i_dout,
    // Captured level
    output logic o_bit
);
    always_ff @(posedge i_clock) begin
        o_bit <= i_dout;
    end
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench of the receiver sequencer
// Assumes: shortened counts, 40 ns clock
// Notes:   reads and state lengths are noted in queues, monitors compare them
`timescale 1ns/100ps
module tb;
    import rxseq_pkg::*;
    localparam int PA = 40, PD = 95, SF = 30, TU = 12, LP = 10;
    logic clk = 0;
    logic rst = 1;
    logic demod = 0;
    rxseq_ahb_req_t req = '0;
    rxseq_ahb_req_t bus;
    rxseq_ahb_rsp_t rsp;
    rxseq_pins_t pins;
    rxseq_pwr_t pwr;
    rxseq_pwr_t prev = '0;
    logic mb, ck_prev = 0, track = 0, skip = 1, rd_ph = 0, first = 1;
    logic [31:0] r;
    logic [4:0] n;
    logic [31:0] rdq[$];
    logic [19:0] phq[$];
    int failures = 0, check_count = 0;
    int cnt = 0, rf_cnt = 0, ck_cnt = 0, stab = 0, half = 0, rx_end = 0;
    always_comb begin
        bus = req;
        bus.hready = rsp.hreadyout;
    end
    initial begin
        forever #20 clk = ~clk;
    end
    rxseq_top #(.P_PWRUP_ALWAYS_CYC(PA), .P_PWRUP_DUTY_CYC(PD), .P_SLEEP_FIXED_CYC(SF),
        .P_TUNE_CYC(TU), .P_LPO_CYC(LP)) u_rxseq_top (.i_clock(clk), .i_reset(rst),
        .i_ahb(bus), .o_ahb(rsp), .i_demod_data(demod), .o_pins(pins), .o_pwr(pwr));
    rxseq_mcu u_rxseq_mcu (.i_clock(clk), .i_dout(pins.dout), .o_bit(mb));
    task automatic cmp_word(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cmp_pin(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_word(s, e, g);
    endtask
    task automatic print_verdict();
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        req.hsel <= 1'b1;
        req.htrans <= 2'b10;
        req.haddr <= {20'h0, a};
        req.hwrite <= w;
        req.hsize <= 3'b010;
        @(posedge clk);
        while (rsp.hreadyout !== 1'b1) @(posedge clk);
        req.hsel <= 1'b0;
        req.htrans <= 2'b00;
        req.hwdata <= d;
        @(posedge clk);
        while (rsp.hreadyout !== 1'b1) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rdq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    always @(posedge clk) begin
        if (rd_ph && rsp.hreadyout === 1'b1) cmp_word("hrdata", rdq.pop_front(), rsp.hrdata);
        if (rd_ph && rsp.hreadyout === 1'b1) cmp_word("hresp", 32'h0, {31'h0, rsp.hresp});
        if (rsp.hreadyout === 1'b1) rd_ph = !rst && bus.hsel && bus.htrans[1] && !bus.hwrite;
    end
    // Lengths of each power pattern; the pattern left before start is not counted
    always @(posedge clk) begin
        if (!track) begin
            skip = 1;
            cnt = 0;
        end else if (pwr !== prev) begin
            if (!skip) cmp_word("phase", phq.pop_front(), {prev, 16'(cnt)});
            skip = 0;
            cnt = 1;
        end else cnt++;
        prev = pwr;
    end
    // Demodulated data held steady for 16 cycles so latency slack cannot hide errors
    always @(posedge clk) begin
        rf_cnt = pwr.rf_on ? rf_cnt + 1 : 0;
        if (rf_cnt > 20 && rf_cnt < rx_end && stab > 8) cmp_pin("dout", demod, mb);
        if (rf_cnt > 2 && rf_cnt < 10) cmp_pin("dout", 32'h0, mb);
        ck_cnt++;
        if (pins.sys_clock_out !== ck_prev && pwr.rf_on) begin
            if (!first || half == 0) cmp_pin("clock", half, ck_cnt);
            first = 0;
            ck_cnt = 0;
        end
        if (!pwr.rf_on) first = 1;
        ck_prev = pins.sys_clock_out;
        if (stab == 15) begin
            demod <= 1'($urandom);
            stab = 0;
        end else stab++;
    end
    initial begin
        #2_000_000;
        failures++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h3a6752a0));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_SLEEP, {5'h0, SLEEP_RST});
        rd(ADDR_RXTIME, {5'h0, RXTIME_RST});
        rd(ADDR_XTAL, {16'h0, XTAL_RST});
        rd(ADDR_STATUS, 32'h0);
        r = $urandom;
        xfer(1'b1, ADDR_SLEEP, r);
        rd(ADDR_SLEEP, r & 32'h07ff_ffff);
        xfer(1'b1, 12'h020, r);
        rd(12'h020, 32'h0);
        n = 5'($urandom % 4);
        xfer(1'b1, ADDR_CTRL, {19'h0, n, 8'h03});
        rd(ADDR_CTRL, {19'h0, n, 8'h03});
        // Zero settings are raised to the shortest legal durations
        xfer(1'b1, ADDR_SLEEP, 32'h0);
        xfer(1'b1, ADDR_RXTIME, 32'h0);
        xfer(1'b1, ADDR_XTAL, 32'h0);
        phq.push_back({4'he, 16'(PD)});
        repeat (2) begin
            phq.push_back({4'h4, 16'(3 * LP)});
            phq.push_back({4'hc, 16'(RX_UNIT_CYC)});
            phq.push_back({4'hd, 16'(TU + RX_UNIT_CYC)});
        end
        half = n + 1;
        rx_end = TU + RX_UNIT_CYC - 7;
        track = 1;
        xfer(1'b1, ADDR_CTRL, {1'b1, 18'h0, n, 8'h03});
        rd(ADDR_STATUS, 32'h0000_0301);
        xfer(1'b1, ADDR_SLEEP, 32'h5);
        xfer(1'b1, ADDR_CTRL, 32'h8000_0000);
        while (phq.size() != 0) @(posedge clk);
        track = 0;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_STATUS, 32'h0);
        phq.push_back({4'h8, 16'(PA)});
        phq.push_back({4'h0, 16'(SF)});
        half = 0;
        rx_end = 1 << 30;
        track = 1;
        xfer(1'b1, ADDR_CTRL, 32'h8000_0000);
        rd(ADDR_STATUS, 32'h0000_0101);
        repeat (PA + SF + 300) @(posedge clk);
        cmp_word("phases left", 32'h0, phq.size());
        print_verdict();
    end
endmodule
